/* File: timer_capture_mode_control.sv */
`timescale 1ns/1ps
module timer_capture_mode_control
  import timer_capture_pkg::*;
#(
  parameter int CHANNEL = 2
) (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic CAPTURE_INPUT_ZERO,
  input wire logic CAPTURE_INPUT_ONE,
  input wire logic PHASE_INPUT_ZERO,
  input wire logic PHASE_INPUT_ONE,
  input wire logic MATCH_OUT_SEVEN,
  input wire logic MATCH_OUT_EIGHT,
  input wire logic MATCH_OUT_NINE
);

  // Pairing with a two-phase pulse counter follows from the channel number.
  localparam bit PHASE_EVEN = (CHANNEL >= 2) && (CHANNEL % 2 == 0);
  localparam bit PHASE_ODD = (CHANNEL >= 3) && (CHANNEL % 2 == 1);

  // Bus, register, edge and counting state.
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [7:0] awaddr_reg, awaddr_next, waddr_word, raddr_word;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next, do_write;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [7:0] control_reg, control_next;
  mode_t mode_reg, mode_next;
  logic count_run_reg, count_run_next, pres_run_reg, pres_run_next, soft_capture;
  logic [15:0] compare_reg, compare_next;
  logic [3:0] sync1_reg, sync2_reg, sync3_reg, rise, fall;
  logic match_src, match_prev_reg, match_rise, match_fall, tick;
  logic [7:0] pres_reg, pres_next;
  logic [15:0] cnt_reg, cnt_next, hold_reg, hold_next, cap0_reg, cap0_next;
  logic [15:0] cap1_reg, cap1_next, counter_view;
  capture_evt_t evt;

  // Handshake outputs follow the holding state directly.
  assign S_AXI_AWREADY = !aw_held_reg;
  assign S_AXI_WREADY = !w_held_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign waddr_word = {awaddr_reg[7:2], 2'b00};
  assign raddr_word = {S_AXI_ARADDR[7:2], 2'b00};
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign counter_view = count_run_reg ? cnt_reg : hold_reg;

  // Bus channels: address and data are taken in either order, the response follows both.
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (S_AXI_AWVALID && !aw_held_reg) begin
      aw_held_next = 1'b1;
      awaddr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_held_reg) begin
      w_held_next = 1'b1;
      wdata_next = S_AXI_WDATA;
      wstrb_next = S_AXI_WSTRB;
    end
    if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (waddr_word <= OFF_CAPTURE_ONE) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end
    if (S_AXI_ARVALID && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = 32'h0000_0000;
      unique case (raddr_word)
        OFF_CONTROL: rdata_next[7:0] = control_reg;
        OFF_MODE: rdata_next[7:0] = {1'b0, 1'b1, mode_reg};
        OFF_RUN: rdata_next[7:0] = {5'b00000, pres_run_reg, 1'b0, count_run_reg};
        OFF_COMPARE_ONE: rdata_next[15:0] = compare_reg;
        OFF_COUNTER: rdata_next[15:0] = counter_view;
        OFF_CAPTURE_ZERO: rdata_next[15:0] = cap0_reg;
        OFF_CAPTURE_ONE: rdata_next[15:0] = cap1_reg;
        default: rresp_next = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // Register writes; a zero in the soft capture bit fires a capture and is not stored.
  always_comb begin
    control_next = control_reg;
    mode_next = mode_reg;
    count_run_next = count_run_reg;
    pres_run_next = pres_run_reg;
    compare_next = compare_reg;
    soft_capture = 1'b0;
    if (do_write && wstrb_reg[0]) begin
      unique case (waddr_word)
        OFF_CONTROL: control_next = wdata_reg[7:0] & CONTROL_MASK;
        OFF_MODE: begin
          mode_next = wdata_reg[MODE_TIMING_POS + 1:MODE_SOURCE_POS];
          soft_capture = !wdata_reg[MODE_SOFT_CAPTURE_POS];
        end
        OFF_RUN: begin
          count_run_next = wdata_reg[RUN_COUNT_POS];
          pres_run_next = wdata_reg[RUN_PRESCALER_POS];
        end
        OFF_COMPARE_ONE: compare_next[7:0] = wdata_reg[7:0];
        default: control_next = control_reg;
      endcase
    end
    if (do_write && wstrb_reg[1] && waddr_word == OFF_COMPARE_ONE) begin
      compare_next[15:8] = wdata_reg[15:8];
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      control_reg <= CONTROL_RESET;
      mode_reg <= MODE_RESET;
      count_run_reg <= RUN_RESET;
      pres_run_reg <= RUN_RESET;
      compare_reg <= COMPARE_RESET;
    end else begin
      control_reg <= control_next;
      mode_reg <= mode_next;
      count_run_reg <= count_run_next;
      pres_run_reg <= pres_run_next;
      compare_reg <= compare_next;
    end
  end

  // Pins pass two flip-flops; the third stage gives the previous level for edges.
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
      match_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {PHASE_INPUT_ONE, PHASE_INPUT_ZERO, CAPTURE_INPUT_ONE, CAPTURE_INPUT_ZERO};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      match_prev_reg <= match_src;
    end
  end

  // Edges of the pins and of the match output of the assigned timer.
  assign rise = sync2_reg & ~sync3_reg;
  assign fall = ~sync2_reg & sync3_reg;
  assign match_src = (CHANNEL <= 1) ? MATCH_OUT_SEVEN :
                     (CHANNEL <= 3) ? MATCH_OUT_EIGHT :
                     (CHANNEL <= 6) ? MATCH_OUT_NINE : 1'b0;
  assign match_rise = match_src && !match_prev_reg;
  assign match_fall = !match_src && match_prev_reg;

  // Capture edge selection per timing code and channel pairing.
  always_comb begin
    evt = '{cap0: 1'b0, cap1: 1'b0};
    unique case (mode_reg.timing)
      CAPT_OFF: evt = '{cap0: 1'b0, cap1: 1'b0};
      CAPT_IN0_IN1: evt = '{cap0: PHASE_EVEN ? rise[2] : rise[0],
        cap1: PHASE_EVEN ? rise[3] : rise[1]};
      CAPT_IN0_BOTH: evt = '{cap0: PHASE_EVEN ? rise[2] : (PHASE_ODD ? rise[3] : rise[0]),
        cap1: PHASE_EVEN ? fall[2] : (PHASE_ODD ? fall[3] : fall[0])};
      CAPT_MATCH: evt = '{cap0: match_rise, cap1: match_fall};
    endcase
  end

  // Count tick from the external pin or from a prescaler tap.
  assign tick = (mode_reg.source == SRC_EXT_PIN) ? rise[0] :
                (pres_run_reg &&
                 ((pres_reg & tap_mask(mode_reg.source)) == tap_mask(mode_reg.source)));

  // Prescaler, counter, stop value and capture registers.
  always_comb begin
    pres_next = pres_run_reg ? pres_reg + 8'h01 : PRESCALE_RESET;
    hold_next = count_run_reg ? cnt_reg : hold_reg;
    cnt_next = cnt_reg;
    if (!count_run_reg) begin
      cnt_next = COUNT_RESET;
    end else if (tick) begin
      if (mode_reg.clear_en && cnt_reg == compare_reg) begin
        cnt_next = COUNT_RESET;
      end else begin
        cnt_next = cnt_reg + 16'h0001;
      end
    end
    cap0_next = (soft_capture || evt.cap0) ? cnt_reg : cap0_reg;
    cap1_next = evt.cap1 ? cnt_reg : cap1_reg;
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pres_reg <= PRESCALE_RESET;
      cnt_reg <= COUNT_RESET;
      hold_reg <= COUNT_RESET;
      cap0_reg <= COUNT_RESET;
      cap1_reg <= COUNT_RESET;
    end else begin
      pres_reg <= pres_next;
      cnt_reg <= cnt_next;
      hold_reg <= hold_next;
      cap0_reg <= cap0_next;
      cap1_reg <= cap1_next;
    end
  end

  // Checks on capture, counting and clearing.
  property p_soft_capture;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      (do_write && wstrb_reg[0] && waddr_word == OFF_MODE && !wdata_reg[6])
        |=> (cap0_reg == $past(cnt_reg));
  endproperty
  a_soft_capture: assert property (p_soft_capture) else $error("soft capture missed");
  property p_no_capture_off;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      (mode_reg.timing == CAPT_OFF) |=> $stable(cap1_reg);
  endproperty
  a_no_capture_off: assert property (p_no_capture_off) else $error("capture while off");
  // The second capture source follows the pairing; even paired channels reach both checks, odd paired channels only the first.
  property p_cap1_input_one;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      (mode_reg.timing == CAPT_IN0_IN1 && (PHASE_EVEN ? rise[3] : rise[1]))
        |=> (cap1_reg == $past(cnt_reg));
  endproperty
  a_cap1_input_one: assert property (p_cap1_input_one) else $error("cap1 on in1 rise missed");
  property p_cap1_fall_zero;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      (mode_reg.timing == CAPT_IN0_BOTH && !PHASE_ODD && (PHASE_EVEN ? fall[2] : fall[0]))
        |=> (cap1_reg == $past(cnt_reg));
  endproperty
  a_cap1_fall_zero: assert property (p_cap1_fall_zero) else $error("cap1 on in0 fall missed");
  property p_match_capture;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      (mode_reg.timing == CAPT_MATCH && match_rise && !soft_capture)
        |=> (cap0_reg == $past(cnt_reg)) && $stable(cap1_reg);
  endproperty
  a_match_capture: assert property (p_match_capture) else $error("match capture wrong");
  property p_match_clear;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      (count_run_reg && tick && mode_reg.clear_en && cnt_reg == compare_reg) |=> (cnt_reg == 16'h0000);
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("no clear on match");
  property p_count_up;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      (count_run_reg && tick && !mode_reg.clear_en) |=> (cnt_reg == $past(cnt_reg) + 16'h0001);
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not step");
  property p_div1_tick;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      (pres_run_reg && mode_reg.source == 3'b001) |-> tick;
  endproperty
  a_div1_tick: assert property (p_div1_tick) else $error("divide by one not every cycle");
  // The counter still shows its last running value in the first stopped cycle and is zero one later.
  property p_stop_clear;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      (count_run_reg ##1 !count_run_reg)
        |-> (counter_view == $past(cnt_reg)) ##1 (cnt_reg == 16'h0000);
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop value wrong");

endmodule : timer_capture_mode_control

/* File: timer_capture_pkg.sv */
package timer_capture_pkg;

  // Byte offsets of the register words on the bus.
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_RUN = 8'h08;
  localparam logic [7:0] OFF_COMPARE_ONE = 8'h0C;
  localparam logic [7:0] OFF_COUNTER = 8'h10;
  localparam logic [7:0] OFF_CAPTURE_ZERO = 8'h14;
  localparam logic [7:0] OFF_CAPTURE_ONE = 8'h18;

  // Control register: writable bit mask and value after reset.
  localparam logic [7:0] CONTROL_MASK = 8'hAF;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Mode register field positions.
  localparam int MODE_SOFT_CAPTURE_POS = 6;
  localparam int MODE_TIMING_POS = 4;
  localparam int MODE_CLEAR_POS = 3;
  localparam int MODE_SOURCE_POS = 0;

  // Run register field positions and reset values.
  localparam int RUN_COUNT_POS = 0;
  localparam int RUN_PRESCALER_POS = 2;
  localparam logic RUN_RESET = 1'b0;

  // Reset values of the counting state.
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;

  // Capture timing codes.
  typedef enum logic [1:0] {
    CAPT_OFF = 2'b00,
    CAPT_IN0_IN1 = 2'b01,
    CAPT_IN0_BOTH = 2'b10,
    CAPT_MATCH = 2'b11
  } capture_timing_t;

  // Count source code that selects the external pin.
  localparam logic [2:0] SRC_EXT_PIN = 3'b000;

  // Mode fields that steer the channel.
  typedef struct packed {
    capture_timing_t timing;
    logic clear_en;
    logic [2:0] source;
  } mode_t;

  localparam mode_t MODE_RESET = '{timing: CAPT_OFF, clear_en: 1'b0, source: 3'b000};

  // Capture events of one cycle.
  typedef struct packed {
    logic cap0;
    logic cap1;
  } capture_evt_t;

  // Bus response codes.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Prescaler bit mask whose all-ones state marks a tick of the chosen tap.
  function automatic logic [7:0] tap_mask(input logic [2:0] sel);
    logic [7:0] m;
    m = 8'h00;
    unique case (sel)
      3'b000: m = 8'h00;
      3'b001: m = 8'h00;
      3'b010: m = 8'h03;
      3'b011: m = 8'h0F;
      3'b100: m = 8'h1F;
      3'b101: m = 8'h3F;
      3'b110: m = 8'h7F;
      3'b111: m = 8'hFF;
    endcase
    return m;
  endfunction : tap_mask

endpackage : timer_capture_pkg

/* File: capture_source_model.sv */
`timescale 1ns/1ps
// Far-side model of the capture pins, two-phase inputs and match outputs.
// Line order: 0 pin zero, 1 pin one, 2 phase zero, 3 phase one, 4..6 match seven..nine.
module capture_source_model (
  input wire logic sys_clk,
  output logic [6:0] lines
);
  // Lines start low so no edge is seen out of reset.
  initial begin
    lines = 7'h00;
  end

  // A line moves just after an edge and then rests long enough for sync and capture.
  task automatic set_line(input int idx, input logic lvl);
    @(posedge sys_clk);
    lines[idx] <= lvl;
    repeat (6) @(posedge sys_clk);
  endtask : set_line

  // Each pulse raises and then lowers one line.
  task automatic pulse_line(input int idx, input int n);
    for (int i = 0; i < n; i++) begin
      set_line(idx, 1'b1);
      set_line(idx, 1'b0);
    end
  endtask : pulse_line
endmodule : capture_source_model

/* File: tb_timer_capture_mode_control.sv */
`timescale 1ns/1ps
// Bench for one paired even channel, driven over the register bus.
module tb_timer_capture_mode_control
  import timer_capture_pkg::*;
();
  logic SYS_CLK;
  logic ARST_N;
  logic [7:0] S_AXI_AWADDR;
  logic S_AXI_AWVALID;
  logic S_AXI_AWREADY;
  logic [31:0] S_AXI_WDATA;
  logic [3:0] S_AXI_WSTRB;
  logic S_AXI_WVALID;
  logic S_AXI_WREADY;
  logic [1:0] S_AXI_BRESP;
  logic S_AXI_BVALID;
  logic S_AXI_BREADY;
  logic [7:0] S_AXI_ARADDR;
  logic S_AXI_ARVALID;
  logic S_AXI_ARREADY;
  logic [31:0] S_AXI_RDATA;
  logic [1:0] S_AXI_RRESP;
  logic S_AXI_RVALID;
  logic S_AXI_RREADY;
  logic [6:0] lines;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int divs [8] = '{1, 1, 4, 16, 32, 64, 128, 256};

  timer_capture_mode_control #(.CHANNEL(2)) DUT (
    .SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .CAPTURE_INPUT_ZERO(lines[0]), .CAPTURE_INPUT_ONE(lines[1]),
    .PHASE_INPUT_ZERO(lines[2]), .PHASE_INPUT_ONE(lines[3]),
    .MATCH_OUT_SEVEN(lines[4]), .MATCH_OUT_EIGHT(lines[5]), .MATCH_OUT_NINE(lines[6])
  );

  capture_source_model u_src (
    .sys_clk(SYS_CLK),
    .lines(lines)
  );

  // Free-running 50 MHz clock.
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end

  // A hang counts as a mismatch and ends the run.
  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_eq

  task automatic check_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    total_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : check_rng

  // Readies are sampled mid-cycle, where they equal their value at the next edge.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_p;
    logic w_p;
    logic done;
    aw_p = 1'b1;
    w_p = 1'b1;
    done = 1'b0;
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (!done) begin
      @(negedge SYS_CLK);
      done = S_AXI_BVALID;
      r = S_AXI_BRESP;
      aw_p = aw_p && !S_AXI_AWREADY;
      w_p = w_p && !S_AXI_WREADY;
      @(posedge SYS_CLK);
      S_AXI_AWVALID <= aw_p;
      S_AXI_WVALID <= w_p;
    end
    S_AXI_BREADY <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_p;
    logic done;
    ar_p = 1'b1;
    done = 1'b0;
    @(posedge SYS_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    while (!done) begin
      @(negedge SYS_CLK);
      done = S_AXI_RVALID;
      d = S_AXI_RDATA;
      r = S_AXI_RRESP;
      ar_p = ar_p && !S_AXI_ARREADY;
      @(posedge SYS_CLK);
      S_AXI_ARVALID <= ar_p;
    end
    S_AXI_RREADY <= 1'b0;
  endtask : axi_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    check_eq(d, exp);
  endtask : rd_chk

  // Mode word with the soft capture bit left at its idle one.
  function automatic logic [31:0] mw(input logic [1:0] t, input logic c, input logic [2:0] s);
    return 32'h40 | (32'(t) << MODE_TIMING_POS) | (32'(c) << MODE_CLEAR_POS) | 32'(s);
  endfunction : mw

  // The mode word is only changed with the channel stopped, which also clears the counter.
  task automatic setup(input logic [1:0] t, input logic c, input logic [2:0] s);
    logic [1:0] r;
    axi_wr(OFF_RUN, 32'h0, r);
    axi_wr(OFF_MODE, mw(t, c, s), r);
    axi_wr(OFF_RUN, 32'h1, r);
  endtask : setup

  // Main sequence of register accesses and line activity.
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    ARST_N = 1'b0;
    S_AXI_AWADDR = 8'h00;
    S_AXI_AWVALID = 1'b0;
    S_AXI_WDATA = 32'h0;
    S_AXI_WSTRB = 4'hF;
    S_AXI_WVALID = 1'b0;
    S_AXI_BREADY = 1'b0;
    S_AXI_ARADDR = 8'h00;
    S_AXI_ARVALID = 1'b0;
    S_AXI_RREADY = 1'b0;
    repeat (6) @(posedge SYS_CLK);
    ARST_N <= 1'b1;
    rd_chk(OFF_MODE, 32'h40);
    rd_chk(OFF_COUNTER, 32'h0);
    axi_wr(OFF_CONTROL, 32'hFFFFFFFF, r);
    check_eq({30'h0, r}, {30'h0, RESP_OKAY});
    rd_chk(OFF_CONTROL, {24'h0, CONTROL_MASK});
    axi_wr(8'h1C, 32'hFFFF, r);
    check_eq({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_rd(8'h1C, d, r);
    check_eq({30'h0, r}, {30'h0, RESP_SLVERR});
    check_eq(d, 32'h0);
    // Paired inputs drive captures; pin one is not a source here.
    setup(CAPT_IN0_IN1, 1'b0, SRC_EXT_PIN);
    u_src.pulse_line(0, 3);
    rd_chk(OFF_COUNTER, 32'h3);
    u_src.pulse_line(2, 1);
    rd_chk(OFF_CAPTURE_ZERO, 32'h3);
    u_src.pulse_line(1, 1);
    rd_chk(OFF_CAPTURE_ONE, 32'h0);
    u_src.pulse_line(0, 2);
    u_src.pulse_line(3, 1);
    rd_chk(OFF_CAPTURE_ONE, 32'h5);
    // Soft capture on a zero, nothing on a one.
    u_src.pulse_line(0, 1);
    axi_wr(OFF_MODE, mw(CAPT_IN0_IN1, 1'b0, SRC_EXT_PIN) & ~32'h40, r);
    rd_chk(OFF_CAPTURE_ZERO, 32'h6);
    axi_wr(OFF_MODE, mw(CAPT_IN0_IN1, 1'b0, SRC_EXT_PIN), r);
    u_src.pulse_line(0, 1);
    rd_chk(OFF_CAPTURE_ZERO, 32'h6);
    axi_wr(OFF_RUN, 32'h0, r);
    rd_chk(OFF_COUNTER, 32'h7);
    // Rising and falling edge of phase zero.
    setup(CAPT_IN0_BOTH, 1'b0, SRC_EXT_PIN);
    u_src.pulse_line(0, 2);
    u_src.set_line(2, 1'b1);
    u_src.pulse_line(0, 1);
    u_src.set_line(2, 1'b0);
    rd_chk(OFF_CAPTURE_ZERO, 32'h2);
    rd_chk(OFF_CAPTURE_ONE, 32'h3);
    // Timing code zero ignores every pin and match source; both capture registers keep their values.
    setup(CAPT_OFF, 1'b0, SRC_EXT_PIN);
    u_src.pulse_line(0, 1);
    u_src.pulse_line(2, 1);
    u_src.pulse_line(3, 1);
    u_src.pulse_line(5, 1);
    rd_chk(OFF_CAPTURE_ZERO, 32'h2);
    rd_chk(OFF_CAPTURE_ONE, 32'h3);
    // Match of timer eight captures; seven and nine must not.
    setup(CAPT_MATCH, 1'b0, SRC_EXT_PIN);
    u_src.pulse_line(0, 1);
    u_src.set_line(5, 1'b1);
    u_src.pulse_line(0, 1);
    u_src.pulse_line(4, 1);
    u_src.set_line(5, 1'b0);
    u_src.pulse_line(0, 1);
    u_src.pulse_line(6, 1);
    rd_chk(OFF_CAPTURE_ZERO, 32'h1);
    rd_chk(OFF_CAPTURE_ONE, 32'h2);
    // Clear on compare one only when enabled.
    axi_wr(OFF_COMPARE_ONE, 32'h2, r);
    setup(CAPT_OFF, 1'b1, SRC_EXT_PIN);
    u_src.pulse_line(0, 3);
    rd_chk(OFF_COUNTER, 32'h0);
    u_src.pulse_line(0, 1);
    rd_chk(OFF_COUNTER, 32'h1);
    setup(CAPT_OFF, 1'b0, SRC_EXT_PIN);
    u_src.pulse_line(0, 3);
    rd_chk(OFF_COUNTER, 32'h3);
    // Each prescaler tap over a fixed window.
    for (int i = 1; i < 8; i++) begin
      axi_wr(OFF_RUN, 32'h0, r);
      axi_wr(OFF_MODE, mw(CAPT_OFF, 1'b0, 3'(i)), r);
      axi_wr(OFF_RUN, 32'h5, r);
      repeat (1024) @(posedge SYS_CLK);
      axi_wr(OFF_RUN, 32'h0, r);
      axi_rd(OFF_COUNTER, d, r);
      check_rng(d, 32'(1024 / divs[i] - 1), 32'(1024 / divs[i] + 8));
    end
    complete_run();
  end
endmodule : tb_timer_capture_mode_control
